/* File: core/mas_pkg.sv */
// Package for the motor algorithm status register bank.
// Assumes a 32-bit Avalon-MM slave with word addressing by index.
`default_nettype none

package mas_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Register indices as printed; byte address is four times the index
    localparam logic [7:0] MAS_IDX_ALGO_STATE  = 8'hE4;
    localparam logic [7:0] MAS_IDX_MOTOR_PARAM = 8'hE6;
    localparam logic [7:0] MAS_IDX_EXTRACT     = 8'hE8;
    localparam int         MAS_ADDR_W          = 10;
    localparam logic [31:0] MAS_RESET_VALUE    = 32'h0000_0000;
    localparam logic [31:0] MAS_UNMAPPED_VALUE = 32'h0000_0000;

    // Field positions of the first status word
    localparam int MAS_VOLT_LSB   = 16;
    localparam int MAS_SPEED_LSB  = 4;
    localparam int MAS_ACTIVE_BIT = 3;
    localparam int MAS_CFG_BIT    = 2;
    localparam int MAS_HOST_BIT   = 1;

    // Field positions of the motor parameter word
    localparam int MAS_RES_LSB  = 24;
    localparam int MAS_BEMF_LSB = 16;
    localparam int MAS_IND_LSB  = 8;

    // Field positions of the extraction status word
    localparam int MAS_R_ST_BIT    = 31;
    localparam int MAS_L_ST_BIT    = 30;
    localparam int MAS_KE_ST_BIT   = 29;
    localparam int MAS_MECH_ST_BIT = 28;
    localparam int MAS_PWMF_LSB    = 24;

    // Full-scale denominators of the scaled fields
    localparam int MAS_VOLT_FULL_SCALE  = 32768;
    localparam int MAS_SPEED_FULL_SCALE = 4096;

    ////////////////////////////////////////////////////////////////////////////////
    // Status inputs produced by the control algorithm
    typedef struct packed {
        logic [15:0] applied_voltage_magnitude;
        logic [11:0] speed_command;
        logic        device_active;
        logic        config_copy_complete;
        logic        host_control_permitted;
    } mas_algo_t;

    typedef struct packed {
        logic [7:0] measured_resistance;
        logic [7:0] measured_back_emf_constant;
        logic [7:0] measured_inductance;
    } mas_motor_t;

    typedef struct packed {
        logic       resistance_measure_state;
        logic       inductance_measure_state;
        logic       back_emf_measure_state;
        logic       mechanical_measure_state;
        logic [3:0] extraction_pwm_frequency;
    } mas_extract_t;

    // Avalon-MM slave request
    typedef struct packed {
        logic [MAS_ADDR_W-1:0] address;
        logic                  read;
        logic                  write;
        logic [31:0]           writedata;
        logic [3:0]            byteenable;
    } mas_avm_req_t;

endpackage

`default_nettype wire

/* File: core/mas_status_regs.sv */
// Read-only status register bank of the motor control algorithm.
// Assumes the algorithm drives its status levels synchronous to sys_clk_i
// and the bus master holds each request until waitrequest falls.
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Functional notes
// [R1] Voltage magnitude, 16 bits at 31:16
// [R2] Speed command, 12 bits at 15:4
// [R3] Bit 3: zero sleep, one active
// [R4] Bit 2: configuration copy into shadow done
// [R5] Bit 1: host may control registers
// [R6] Resistance, 8 bits at 31:24
// [R7] Back-EMF constant, 8 bits at 23:16
// [R8] Inductance, 8 bits at 15:8
// [R9] Bit 31: resistance measurement status
// [R10] Bit 30: inductance measurement status
// [R11] Bit 29: back-EMF measurement status
// [R12] Bit 28: mechanical measurement status
// [R13] PWM frequency code at 27:24
// [R14] Words at E4h, E6h, E8h, reset zero
// [R15] Host leaves unmapped offsets untouched; the bench reads random unmapped offsets, which the bank answers with SLVERR
// [R16] Reads harmless, writes ignored, reserved zero
module mas_status_regs (
    // Clock and reset
    input  wire logic                    sys_clk_i,
    input  wire logic                    sys_rst_i,
    // Algorithm status
    input  wire mas_pkg::mas_algo_t      algo_i,
    input  wire mas_pkg::mas_motor_t     motor_i,
    input  wire mas_pkg::mas_extract_t   extract_i,
    // Avalon-MM slave
    input  wire mas_pkg::mas_avm_req_t   avm_i,
    output logic [31:0]                  avm_readdata_o,
    output logic                         avm_waitrequest_o,
    output logic [1:0]                   avm_response_o
);
    import mas_pkg::*;

    typedef enum logic [0:0] { MAS_IDLE, MAS_DONE } mas_state_t;

    logic [31:0] algo_word;
    logic [31:0] motor_word;
    logic [31:0] extract_word;
    logic [31:0] next_algo_word;
    logic [31:0] next_motor_word;
    logic [31:0] next_extract_word;
    logic [31:0] next_readdata;
    logic [1:0]  next_response;
    mas_state_t  state;
    mas_state_t  next_state;

    // Register index decode, shared by read path and checks
    function automatic logic [1:0] mas_decode(input logic [MAS_ADDR_W-1:0] a);
        logic [1:0] sel;
        sel = 2'h0;
        if (a == {2'h0, MAS_IDX_ALGO_STATE}) begin
            sel = 2'h1;
        end else if (a == {2'h0, MAS_IDX_MOTOR_PARAM}) begin
            sel = 2'h2;
        end else if (a == {2'h0, MAS_IDX_EXTRACT}) begin
            sel = 2'h3;
        end
        return sel;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Status word assembly; unlisted bits stay zero
    always_comb begin
        next_algo_word    = MAS_RESET_VALUE;
        next_motor_word   = MAS_RESET_VALUE;
        next_extract_word = MAS_RESET_VALUE;
        // [R1] voltage magnitude field
        next_algo_word[MAS_VOLT_LSB +: 16] = algo_i.applied_voltage_magnitude;
        // [R2] speed command field
        next_algo_word[MAS_SPEED_LSB +: 12] = algo_i.speed_command;
        // [R3] sleep or active
        next_algo_word[MAS_ACTIVE_BIT] = algo_i.device_active;
        // [R4] configuration copy done
        next_algo_word[MAS_CFG_BIT] = algo_i.config_copy_complete;
        // [R5] host control permitted
        next_algo_word[MAS_HOST_BIT] = algo_i.host_control_permitted;
        // [R6] resistance field
        next_motor_word[MAS_RES_LSB +: 8] = motor_i.measured_resistance;
        // [R7] back-EMF field
        next_motor_word[MAS_BEMF_LSB +: 8] = motor_i.measured_back_emf_constant;
        // [R8] inductance field
        next_motor_word[MAS_IND_LSB +: 8] = motor_i.measured_inductance;
        // [R9] resistance status
        next_extract_word[MAS_R_ST_BIT] = extract_i.resistance_measure_state;
        // [R10] inductance status
        next_extract_word[MAS_L_ST_BIT] = extract_i.inductance_measure_state;
        // [R11] back-EMF status
        next_extract_word[MAS_KE_ST_BIT] = extract_i.back_emf_measure_state;
        // [R12] mechanical status
        next_extract_word[MAS_MECH_ST_BIT] = extract_i.mechanical_measure_state;
        // [R13] PWM frequency code
        next_extract_word[MAS_PWMF_LSB +: 4] = extract_i.extraction_pwm_frequency;
    end

    // Snapshot registers give software a stable one-cycle-old copy
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            // [R14] reset to zero
            algo_word    <= MAS_RESET_VALUE;
            motor_word   <= MAS_RESET_VALUE;
            extract_word <= MAS_RESET_VALUE;
        end else begin
            algo_word    <= next_algo_word;
            motor_word   <= next_motor_word;
            extract_word <= next_extract_word;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus answer: one wait cycle, then the answer with waitrequest low
    always_comb begin
        next_state    = state;
        next_readdata = avm_readdata_o;
        next_response = avm_response_o;
        case (state)
            MAS_IDLE: begin
                if (avm_i.read || avm_i.write) begin
                    next_state    = MAS_DONE;
                    next_readdata = MAS_UNMAPPED_VALUE;
                    next_response = 2'h2; // Unmapped answers SLVERR
                    // [R14] decode of the three words
                    if (mas_decode(avm_i.address) == 2'h1) begin
                        next_response = 2'h0;
                        next_readdata = avm_i.read ? algo_word : MAS_UNMAPPED_VALUE;
                    end else if (mas_decode(avm_i.address) == 2'h2) begin
                        next_response = 2'h0;
                        next_readdata = avm_i.read ? motor_word : MAS_UNMAPPED_VALUE;
                    end else if (mas_decode(avm_i.address) == 2'h3) begin
                        next_response = 2'h0;
                        next_readdata = avm_i.read ? extract_word : MAS_UNMAPPED_VALUE;
                    end
                    // [R16] writes change nothing
                    if (avm_i.write) begin
                        next_readdata = MAS_UNMAPPED_VALUE;
                    end
                end
            end
            MAS_DONE: begin
                next_state = MAS_IDLE;
            end
            default: begin
                next_state = MAS_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            state          <= MAS_IDLE;
            avm_readdata_o <= 32'h0000_0000;
            avm_response_o <= 2'h0;
        end else begin
            state          <= next_state;
            avm_readdata_o <= next_readdata;
            avm_response_o <= next_response;
        end
    end

    // Handshake: low only in the answer cycle
    assign avm_waitrequest_o = (state != MAS_DONE);

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    // Requests taken while idle; one request is outstanding at a time
    sequence s_read_taken;
        avm_i.read && state == MAS_IDLE;
    endsequence

    sequence s_write_taken;
        avm_i.write && state == MAS_IDLE;
    endsequence

    // Answer cycle of a mapped word: waitrequest low with an OKAY response
    sequence s_answer_okay;
        !avm_waitrequest_o && avm_response_o == 2'h0;
    endsequence

    // Field checks look one edge back; the antecedent skips the edge that
    // releases reset, where the snapshot still holds its reset zeros
    // [R1] voltage magnitude
    AST_VOLT_FIELD: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R1]
        !sys_rst_i |=> algo_word[31:16] == $past(algo_i.applied_voltage_magnitude))
        else $error("voltage field mismatch");

    // [R2] speed command
    AST_SPEED_FIELD: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R2]
        !sys_rst_i |=> algo_word[15:4] == $past(algo_i.speed_command))
        else $error("speed field mismatch");

    // [R3] sleep or active
    AST_FLAG_BITS: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R3]
        !sys_rst_i |=> algo_word[3] == $past(algo_i.device_active) && algo_word[2] == $past(algo_i.config_copy_complete)
                       && algo_word[1] == $past(algo_i.host_control_permitted) && !algo_word[0])
        else $error("flag bits mismatch");

    // [R4] copy done flag
    AST_CFG_BIT: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R4]
        !sys_rst_i |=> algo_word[2] == $past(algo_i.config_copy_complete))
        else $error("configuration copy flag mismatch");

    // [R5] host control flag
    AST_HOST_BIT: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R5]
        !sys_rst_i |=> algo_word[1] == $past(algo_i.host_control_permitted))
        else $error("host control flag mismatch");

    // [R6] resistance and word
    AST_MOTOR_WORD: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R6]
        !sys_rst_i |=> motor_word == {$past(motor_i), 8'h00})
        else $error("motor word mismatch");

    // [R7] back-EMF field
    AST_BEMF_FIELD: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R7]
        !sys_rst_i |=> motor_word[23:16] == $past(motor_i.measured_back_emf_constant))
        else $error("back-EMF field mismatch");

    // [R8] inductance field
    AST_IND_FIELD: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R8]
        !sys_rst_i |=> motor_word[15:8] == $past(motor_i.measured_inductance))
        else $error("inductance field mismatch");

    // [R9] resistance status and word
    AST_EXTRACT_WORD: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R9]
        !sys_rst_i |=> extract_word == {$past(extract_i), 24'h000000})
        else $error("extraction word mismatch");

    // [R10] inductance status
    AST_L_STATUS: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R10]
        !sys_rst_i |=> extract_word[30] == $past(extract_i.inductance_measure_state))
        else $error("inductance status mismatch");

    // [R11] back-EMF status
    AST_KE_STATUS: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R11]
        !sys_rst_i |=> extract_word[29] == $past(extract_i.back_emf_measure_state))
        else $error("back-EMF status mismatch");

    // [R12] mechanical status
    AST_MECH_STATUS: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R12]
        !sys_rst_i |=> extract_word[28] == $past(extract_i.mechanical_measure_state))
        else $error("mechanical status mismatch");

    // [R13] PWM frequency code
    AST_PWMF_FIELD: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R13]
        !sys_rst_i |=> extract_word[27:24] == $past(extract_i.extraction_pwm_frequency))
        else $error("PWM frequency code mismatch");

    // Bus checks: the answer follows the taking edge by exactly one cycle
    // [R14] word at E4h
    AST_READ_ALGO: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R14]
        s_read_taken ##0 (avm_i.address == {2'h0, MAS_IDX_ALGO_STATE})
        |=> s_answer_okay ##0 avm_readdata_o == $past(algo_word))
        else $error("algorithm word read wrong");

    // [R14] word at E6h
    AST_READ_MOTOR: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R14]
        s_read_taken ##0 (avm_i.address == {2'h0, MAS_IDX_MOTOR_PARAM})
        |=> s_answer_okay ##0 avm_readdata_o == $past(motor_word))
        else $error("motor word read wrong");

    // [R14] word at E8h
    AST_READ_EXTRACT: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R14]
        s_read_taken ##0 (avm_i.address == {2'h0, MAS_IDX_EXTRACT})
        |=> s_answer_okay ##0 avm_readdata_o == $past(extract_word))
        else $error("extraction word read wrong");

    // [R16] unmapped reads harmless
    AST_READ_UNMAPPED: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R16]
        s_read_taken ##0 (mas_decode(avm_i.address) == 2'h0)
        |=> avm_readdata_o == 32'h0000_0000 && avm_response_o == 2'h2)
        else $error("unmapped read wrong");

    // [R16] writes ignored
    AST_WRITE_IGNORED: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R16]
        s_write_taken |=> !avm_waitrequest_o && avm_readdata_o == 32'h0000_0000 ##1 avm_waitrequest_o)
        else $error("write answer wrong");

    // [R16] mapped write OKAY
    AST_WRITE_OKAY: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R16]
        s_write_taken ##0 (mas_decode(avm_i.address) != 2'h0)
        |=> s_answer_okay)
        else $error("mapped write response wrong");

    // [R14] one answer cycle
    AST_ANSWER_ONE_CYCLE: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R14]
        !avm_waitrequest_o |=> avm_waitrequest_o)
        else $error("answer held too long");

    // [R14] reset zeros
    AST_RESET_ZERO: assert property (@(posedge sys_clk_i) // [R14]
        sys_rst_i |=> algo_word == MAS_RESET_VALUE && motor_word == MAS_RESET_VALUE
                      && extract_word == MAS_RESET_VALUE && avm_waitrequest_o
                      && avm_readdata_o == 32'h0000_0000)
        else $error("reset values wrong");

    // [R16] reserved bits zero
    AST_RESERVED_ZERO: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i) // [R16]
        algo_word[0] == 1'h0 && motor_word[7:0] == 8'h00
        && extract_word[23:0] == 24'h00_0000)
        else $error("reserved bits not zero");

endmodule

`default_nettype wire

/* File: sim/mas_status_regs_bench.sv */
// Self-checking bench for the read-only motor algorithm status register bank.
// Assumes one clock, synchronous reset and an Avalon-MM slave that raises waitrequest.
`default_nettype none

module mas_status_regs_bench import mas_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    logic         sys_clk_i;
    logic         sys_rst_i;
    mas_algo_t    algo_i;
    mas_motor_t   motor_i;
    mas_extract_t extract_i;
    mas_avm_req_t avm_i;
    logic [31:0]  avm_readdata_o;
    logic         avm_waitrequest_o;
    logic [1:0]   avm_response_o;
    int           miscompares;
    int           total_checks;
    logic [31:0]  rd;
    logic [1:0]   rsp;
    logic [9:0]   idx;
    logic [9:0]   maps [3] = '{10'h0E4, 10'h0E6, 10'h0E8};

    mas_status_regs u_dut (
        .sys_clk_i         (sys_clk_i),
        .sys_rst_i         (sys_rst_i),
        .algo_i            (algo_i),
        .motor_i           (motor_i),
        .extract_i         (extract_i),
        .avm_i             (avm_i),
        .avm_readdata_o    (avm_readdata_o),
        .avm_waitrequest_o (avm_waitrequest_o),
        .avm_response_o    (avm_response_o)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Free-running 100 MHz clock
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end

    // Compare and count
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One bus cycle; the request is held until waitrequest is sampled low at a
    // rising edge, and the answer is taken and the request dropped at that edge
    task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] wd);
        @(posedge sys_clk_i);
        avm_i <= '{address: a, read: !wr, write: wr, writedata: wd, byteenable: 4'($urandom)};
        // No cycle count is assumed; the watchdog ends a hung wait
        do begin
            @(posedge sys_clk_i);
        end while (avm_waitrequest_o !== 1'b0);
        rd = avm_readdata_o;
        rsp = avm_response_o;
        avm_i.read <= 1'b0;
        avm_i.write <= 1'b0;
    endtask

    // Expected word from the status levels currently driven
    function automatic logic [31:0] expect_word(input logic [9:0] a);
        case (a)
            10'h0E4: return {algo_i.applied_voltage_magnitude, algo_i.speed_command, algo_i.device_active,
                             algo_i.config_copy_complete, algo_i.host_control_permitted, 1'b0};
            10'h0E6: return {motor_i.measured_resistance, motor_i.measured_back_emf_constant,
                             motor_i.measured_inductance, 8'h00};
            10'h0E8: return {extract_i, 24'h000000};
            default: return 32'h0000_0000;
        endcase
    endfunction

    task automatic summarize;
        $display("checks %0d, mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Watchdog: the whole run needs about nine hundred cycles
    initial begin
        repeat (5000) @(posedge sys_clk_i);
        miscompares++;
        summarize();
    end

    // Main sequence
    initial begin
        sys_rst_i = 1'b1;
        algo_i = '0;
        motor_i = '0;
        extract_i = '0;
        avm_i = '0;
        miscompares = 0;
        total_checks = 0;
        void'($urandom(32'h9057A715));
        // Reset is sampled high at three edges and dropped at the third
        repeat (2) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        check(avm_readdata_o, 32'h0000_0000, "data in reset");
        check({31'h0, avm_waitrequest_o}, 32'h0000_0001, "wait in reset");
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            bus(1'b0, maps[k], 32'h0000_0000);
            check(rd, 32'h0000_0000, "reset word");
        end
        // Random levels, first pass all ones to expose reserved bits
        for (int i = 0; i < 40; i++) begin
            @(posedge sys_clk_i);
            algo_i <= (i == 0) ? '1 : 31'($urandom);
            motor_i <= (i == 0) ? '1 : 24'($urandom);
            extract_i <= (i == 0) ? '1 : 8'($urandom);
            for (int k = 0; k < 3; k++) begin
                bus(1'b1, maps[k], $urandom);
                check({30'h0, rsp}, 32'h0000_0000, "write response");
                bus(1'b0, maps[k], 32'h0000_0000);
                check(rd, expect_word(maps[k]), "status");
                check({30'h0, rsp}, 32'h0000_0000, "read response");
            end
            idx = 10'($urandom);
            if (idx == 10'h0E4 || idx == 10'h0E6 || idx == 10'h0E8) begin
                idx = idx ^ 10'h001;
            end
            bus(1'b0, idx, 32'h0000_0000);
            check(rd, 32'h0000_0000, "unmapped data");
            check({30'h0, rsp}, 32'h0000_0002, "unmapped response");
        end
        // Second reset in mid-run
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        @(negedge sys_clk_i);
        check(avm_readdata_o, 32'h0000_0000, "data in second reset");
        check({31'h0, avm_waitrequest_o}, 32'h0000_0001, "wait in second reset");
        @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        bus(1'b0, 10'h0E8, 32'h0000_0000);
        check(rd, expect_word(10'h0E8), "after second reset");
        summarize();
    end

endmodule

`default_nettype wire
